// [core/iepb_ctrl.sv]
// Contract
// - Enable bit 7 gates every source; zero blocks all interrupts.
// - Enable bit 6 allows the counter array interrupt.
// - Enable bit 5 allows the timer 2 overflow interrupt.
// - Enable bit 4 allows the serial port interrupt.
// - Enable bit 3 allows the timer 1 overflow interrupt.
// - Enable bit 2 allows the external input 1 interrupt.
// - Enable bit 1 allows the timer 0 overflow interrupt.
// - Enable bit 0 allows the external input 0 interrupt.
// - Counter array level is high bit 6 over low bit 6.
// - Timer 2 level is high bit 5 over low bit 5.
// - Serial level from bit 4 pair; 00 lowest, 11 highest.
// - Priority bit 7 reserved; software never sets it, reads undefined.
// - Enable register resets to zero and allows single-bit set and clear.
// - Priority-low resets to zero and allows single-bit set and clear.
// - Priority-high resets to zero, whole-byte access only.
// - Bit pair 00 is level 0 lowest, 11 is level 3 highest.
// - Only a strictly higher level pre-empts; level 3 is never pre-empted.
// - Among simultaneous requests the higher level is served first.
// - Equal levels are resolved by a fixed polling order.
//
// Chosen here: register access over APB.

`timescale 1ns/1ps
`default_nettype none

module iepb_ctrl #(
  parameter int NSRC = iepb_pkg::NSRC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [iepb_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [iepb_pkg::DATA_W-1:0] pwdata_in,
  output logic [iepb_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Peripheral requests and CPU core
  input wire logic [NSRC-1:0] irq_req_in,
  input wire logic irq_ack_in,
  input wire logic irq_done_in,
  output iepb_pkg::iepb_irq_t irq_out,
  output logic [iepb_pkg::NLEVEL-1:0] in_service_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bit_apply(
    input logic [7:0] val,
    input logic [2:0] idx,
    input logic set
  );
    logic [7:0] res;
    res = val;
    res[idx] = set;
    return res;
  endfunction : bit_apply

  function automatic logic [1:0] top_level(
    input logic [iepb_pkg::NLEVEL-1:0] act
  );
    logic [1:0] lvl;
    lvl = 2'h0;
    for (int i = 0; i < iepb_pkg::NLEVEL; i++) begin
      if (act[i]) begin
        lvl = 2'(i);
      end
    end
    return lvl;
  endfunction : top_level

  function automatic logic reg_hit(
    input logic [iepb_pkg::ADDR_W-1:0] addr,
    input logic [7:0] idx
  );
    return addr == {2'h0, idx, 2'h0};
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  iepb_pkg::iepb_apb_state_t state_ff;
  iepb_pkg::iepb_apb_state_t nxt_state;
  logic [7:0] en_ff;
  logic [7:0] ph_ff;
  logic [7:0] pl_ff;
  logic [iepb_pkg::NLEVEL-1:0] insvc_ff;
  logic [iepb_pkg::NLEVEL-1:0] nxt_insvc;
  iepb_pkg::iepb_irq_t irq_ff;
  iepb_pkg::iepb_irq_t nxt_irq;
  logic [iepb_pkg::DATA_W-1:0] prdata_ff;
  logic [iepb_pkg::DATA_W-1:0] nxt_prdata;
  logic pready_ff;
  logic pslverr_ff;
  logic nxt_err;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit_en;
  logic hit_ph;
  logic hit_pl;
  logic hit_bitop;
  logic hit_stat;
  logic hit_any;
  logic [2:0] bitop_sel;
  logic [1:0] bitop_tgt;
  logic bitop_set;

  assign hit_en = reg_hit(paddr_in, iepb_pkg::IDX_EN);
  assign hit_ph = reg_hit(paddr_in, iepb_pkg::IDX_PH);
  assign hit_pl = reg_hit(paddr_in, iepb_pkg::IDX_PL);
  assign hit_bitop = reg_hit(paddr_in, iepb_pkg::IDX_BITOP);
  assign hit_stat = reg_hit(paddr_in, iepb_pkg::IDX_STAT);
  assign hit_any = hit_en | hit_ph | hit_pl | hit_bitop | hit_stat;
  assign bitop_sel = pwdata_in[iepb_pkg::BITOP_SEL_LSB +: 3];
  assign bitop_tgt = pwdata_in[iepb_pkg::BITOP_TGT_LSB +: 2];
  assign bitop_set = pwdata_in[iepb_pkg::BITOP_SET_POS];

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // One wait state: read data and error are frozen into flops so every
  // bus output leaves a register.
  logic access;
  logic commit;

  assign access = psel_in & penable_in;
  assign commit = (state_ff == iepb_pkg::APB_RESP) & access & pwrite_in & ~pslverr_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      iepb_pkg::APB_IDLE: begin
        if (access) begin
          nxt_state = iepb_pkg::APB_RESP;
        end
      end
      iepb_pkg::APB_RESP: begin
        nxt_state = iepb_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_ff <= iepb_pkg::APB_IDLE;
    end else if (ce_in) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pready_ff <= 1'b0;
    end else if (ce_in) begin
      pready_ff <= (state_ff == iepb_pkg::APB_IDLE) & access;
    end
  end

  // ----------------------------------------------------------------
  // Read data and error
  // ----------------------------------------------------------------
  always_comb begin
    nxt_prdata = '0;
    if (!pwrite_in) begin
      if (hit_en) begin
        nxt_prdata[7:0] = en_ff;
      end else if (hit_ph) begin
        nxt_prdata[7:0] = ph_ff & iepb_pkg::PRIO_MASK;
      end else if (hit_pl) begin
        nxt_prdata[7:0] = pl_ff & iepb_pkg::PRIO_MASK;
      end else if (hit_stat) begin
        nxt_prdata[iepb_pkg::STAT_SRC_LSB +: 3] = irq_ff.src;
        nxt_prdata[iepb_pkg::STAT_LVL_LSB +: 2] = irq_ff.level;
        nxt_prdata[iepb_pkg::STAT_VALID_POS] = irq_ff.valid;
        nxt_prdata[iepb_pkg::STAT_INSVC_LSB +: iepb_pkg::NLEVEL] = insvc_ff;
      end
    end
  end

  // Refused: unmapped address, writes to status, and bit operations
  // aimed at any target other than enable or priority-low.
  always_comb begin
    nxt_err = ~hit_any;
    if (pwrite_in && hit_stat) begin
      nxt_err = 1'b1;
    end
    if (pwrite_in && hit_bitop && bitop_tgt != iepb_pkg::TGT_EN
        && bitop_tgt != iepb_pkg::TGT_PL) begin
      nxt_err = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
    end else if (ce_in) begin
      if (state_ff == iepb_pkg::APB_IDLE && access) begin
        prdata_ff <= nxt_prdata;
        pslverr_ff <= nxt_err;
      end else begin
        prdata_ff <= '0;
        pslverr_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      en_ff <= iepb_pkg::EN_RST;
    end else if (ce_in && commit) begin
      if (hit_en) begin
        en_ff <= pwdata_in[7:0];
      end else if (hit_bitop && bitop_tgt == iepb_pkg::TGT_EN) begin
        en_ff <= bit_apply(en_ff, bitop_sel, bitop_set);
      end
    end
  end

  // ----------------------------------------------------------------
  // Priority registers
  // ----------------------------------------------------------------
  // Reserved bit 7 is never stored, so a stray one cannot shift a level.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pl_ff <= iepb_pkg::PL_RST;
    end else if (ce_in && commit) begin
      if (hit_pl) begin
        pl_ff <= pwdata_in[7:0] & iepb_pkg::PRIO_MASK;
      end else if (hit_bitop && bitop_tgt == iepb_pkg::TGT_PL) begin
        pl_ff <= bit_apply(pl_ff, bitop_sel, bitop_set) & iepb_pkg::PRIO_MASK;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ph_ff <= iepb_pkg::PH_RST;
    end else if (ce_in && commit && hit_ph) begin
      ph_ff <= pwdata_in[7:0] & iepb_pkg::PRIO_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Gating and arbitration
  // ----------------------------------------------------------------
  logic [NSRC-1:0] src_en;
  logic [NSRC-1:0] eligible;
  iepb_pkg::iepb_prio_t prio;
  logic win_found;
  logic [2:0] win_src;
  logic [1:0] win_level;

  // Each source bit lines up with its enable bit.
  always_comb begin
    src_en = '0;
    src_en[iepb_pkg::SRC_CA] = en_ff[iepb_pkg::SRC_CA];
    src_en[iepb_pkg::SRC_TIMER2] = en_ff[iepb_pkg::SRC_TIMER2];
    src_en[iepb_pkg::SRC_SERIAL] = en_ff[iepb_pkg::SRC_SERIAL];
    src_en[iepb_pkg::SRC_TIMER1] = en_ff[iepb_pkg::SRC_TIMER1];
    src_en[iepb_pkg::SRC_EXT1] = en_ff[iepb_pkg::SRC_EXT1];
    src_en[iepb_pkg::SRC_TIMER0] = en_ff[iepb_pkg::SRC_TIMER0];
    src_en[iepb_pkg::SRC_EXT0] = en_ff[iepb_pkg::SRC_EXT0];
  end

  assign eligible = irq_req_in & src_en & {NSRC{en_ff[iepb_pkg::EN_GLOBAL_POS]}};

  // High register bit is the upper bit of each level.
  assign prio.high = ph_ff[NSRC-1:0];
  assign prio.low = pl_ff[NSRC-1:0];

  iepb_arbiter #(
    .NSRC(NSRC)
  ) u_arbiter (
    .eligible_in(eligible),
    .prio_in(prio),
    .found_out(win_found),
    .src_out(win_src),
    .level_out(win_level)
  );

  // ----------------------------------------------------------------
  // In-service tracking
  // ----------------------------------------------------------------
  // A return retires the highest active level before a new take lands,
  // so both in one cycle leave a consistent stack.
  always_comb begin
    nxt_insvc = insvc_ff;
    if (irq_done_in && insvc_ff != '0) begin
      nxt_insvc[top_level(insvc_ff)] = 1'b0;
    end
    if (irq_ack_in && irq_ff.valid) begin
      nxt_insvc[irq_ff.level] = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      insvc_ff <= '0;
    end else if (ce_in) begin
      insvc_ff <= nxt_insvc;
    end
  end

  // ----------------------------------------------------------------
  // Request to the core
  // ----------------------------------------------------------------
  // Offer is withdrawn the cycle after a take; the in-service stack
  // catches up on that same edge, so no source is offered twice.
  logic preempt_ok;

  always_comb begin
    if (insvc_ff == '0) begin
      preempt_ok = 1'b1;
    end else begin
      preempt_ok = win_level > top_level(insvc_ff);
    end
  end

  always_comb begin
    nxt_irq = '0;
    if (win_found && preempt_ok && !irq_ack_in) begin
      nxt_irq.valid = 1'b1;
      nxt_irq.src = win_src;
      nxt_irq.level = win_level;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_ff <= '0;
    end else if (ce_in) begin
      irq_ff <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign irq_out = irq_ff;
  assign in_service_out = insvc_ff;

endmodule : iepb_ctrl

`default_nettype wire

// [core/iepb_pkg.sv]
package iepb_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int NSRC = 7;
  localparam int NLEVEL = 4;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_EN = 8'ha8;
  localparam logic [7:0] IDX_PH = 8'hb7;
  localparam logic [7:0] IDX_PL = 8'hb8;
  localparam logic [7:0] IDX_BITOP = 8'hc0;
  localparam logic [7:0] IDX_STAT = 8'hc1;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int EN_GLOBAL_POS = 7;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TIMER0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TIMER1 = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_TIMER2 = 5;
  localparam int SRC_CA = 6;
  localparam int PRIO_RSVD_POS = 7;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] PH_RST = 8'h00;
  localparam logic [7:0] PL_RST = 8'h00;
  localparam logic [7:0] PRIO_MASK = 8'h7f;

  // Bit operation register fields
  localparam int BITOP_SEL_LSB = 0;
  localparam int BITOP_TGT_LSB = 4;
  localparam int BITOP_SET_POS = 8;
  localparam logic [1:0] TGT_EN = 2'h0;
  localparam logic [1:0] TGT_PL = 2'h1;
  localparam logic [1:0] TGT_PH = 2'h2;

  // Status register fields
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_LVL_LSB = 4;
  localparam int STAT_VALID_POS = 7;
  localparam int STAT_INSVC_LSB = 8;

  localparam logic [1:0] LEVEL_TOP = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {
    APB_IDLE = 1'b0,
    APB_RESP = 1'b1
  } iepb_apb_state_t;

  typedef struct packed {
    logic valid;
    logic [2:0] src;
    logic [1:0] level;
  } iepb_irq_t;

  typedef struct packed {
    logic [NSRC-1:0] high;
    logic [NSRC-1:0] low;
  } iepb_prio_t;

endpackage : iepb_pkg

// [core/iepb_arbiter.sv]
`timescale 1ns/1ps
`default_nettype none

module iepb_arbiter #(
  parameter int NSRC = 7
) (
  input wire logic [NSRC-1:0] eligible_in,
  input wire iepb_pkg::iepb_prio_t prio_in,
  output logic found_out,
  output logic [2:0] src_out,
  output logic [1:0] level_out
);

  // ----------------------------------------------------------------
  // Level first, then fixed polling order
  // ----------------------------------------------------------------
  // Lower source index polls first; scan from the top down so the last
  // hit at a given level is the lowest index.
  always_comb begin
    logic [1:0] lvl;
    lvl = 2'h0;
    found_out = 1'b0;
    src_out = 3'h0;
    level_out = 2'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      lvl = {prio_in.high[i], prio_in.low[i]};
      if (eligible_in[i]) begin
        if (!found_out || lvl > level_out) begin
          found_out = 1'b1;
          src_out = 3'(i);
          level_out = lvl;
        end else if (lvl == level_out) begin
          src_out = 3'(i);
        end
      end
    end
  end

endmodule : iepb_arbiter

`default_nettype wire

// [verif/iepb_ctrl_sva.sv]
`timescale 1ns/1ps
`default_nettype none

module iepb_ctrl_chk #(
  parameter int NSRC = 7
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [iepb_pkg::DATA_W-1:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [NSRC-1:0] irq_req_in,
  input wire logic irq_ack_in,
  input wire logic irq_done_in,
  input wire iepb_pkg::iepb_irq_t irq_out,
  input wire logic [iepb_pkg::NLEVEL-1:0] in_service_out
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence taken_s;
    psel_in && penable_in && ce_in && !pready_out;
  endsequence
  sequence pulse_s;
    pready_out ##1 !pready_out;
  endsequence
  apb_answer_a: assert property (taken_s |=> pulse_s)
    else $error("no ready pulse");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready_out |-> prdata_out == '0)
    else $error("read data outside answer");
  req_cause_a: assert property (irq_out.valid && $past(ce_in) |->
    (($past(irq_req_in) >> irq_out.src) & NSRC'(1)) != '0) else $error("offer without request");
  ack_take_a: assert property (irq_out.valid && irq_ack_in && !irq_done_in |=>
    !irq_out.valid && in_service_out[$past(irq_out.level)]) else $error("ack not taken");
  top_level_a: assert property (in_service_out[3] |-> !irq_out.valid)
    else $error("top level pre-empted");
  preempt_level_a: assert property (irq_out.valid |-> (in_service_out >> irq_out.level) == '0)
    else $error("pre-empt by equal or lower level");
  done_clear_a: assert property (irq_done_in && !irq_ack_in && $onehot(in_service_out) |=>
    in_service_out == '0) else $error("done did not clear");
  reset_clear_a: assert property ($fell(rst_in) |-> irq_out == '0 && in_service_out == '0)
    else $error("outputs not cleared");
endmodule : iepb_ctrl_chk

bind iepb_ctrl iepb_ctrl_chk #(.NSRC(NSRC)) chk_i (.clock_in(clock_in), .rst_in(rst_in),
  .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_req_in(irq_req_in),
  .irq_ack_in(irq_ack_in), .irq_done_in(irq_done_in), .irq_out(irq_out),
  .in_service_out(in_service_out));

`default_nettype wire

// [verif/iepb_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none

module iepb_cpu_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire iepb_pkg::iepb_irq_t irq_in,
  input wire logic go_in,
  input wire logic done_req_in,
  input wire logic [1:0] dly_in,
  output logic ack_out,
  output logic done_out
);
  // ----
  // One ack per go pulse
  // ----
  // Ack only a standing offer, after dly_in cycles of it
  logic armed_ff;
  logic [1:0] wait_ff;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      armed_ff <= 1'b0;
      wait_ff <= 2'h0;
      ack_out <= 1'b0;
    end else begin
      ack_out <= 1'b0;
      if (go_in) begin
        armed_ff <= 1'b1;
      end
      if (!irq_in.valid) begin
        wait_ff <= 2'h0;
      end else if (armed_ff && wait_ff == dly_in) begin
        ack_out <= 1'b1;
        armed_ff <= 1'b0;
        wait_ff <= 2'h0;
      end else if (armed_ff) begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    done_out <= !rst_in && done_req_in;
  end
endmodule : iepb_cpu_model

`default_nettype wire

// [verif/test_int_enable_priority_bank0.sv]
`timescale 1ns/1ps
`default_nettype none

module test_int_enable_priority_bank0;
  typedef struct {logic rd; logic [31:0] d; logic er;} iepb_exp_t;
  localparam logic [11:0] A_EN = {2'h0, iepb_pkg::IDX_EN, 2'h0};
  localparam logic [11:0] A_PH = {2'h0, iepb_pkg::IDX_PH, 2'h0};
  localparam logic [11:0] A_PL = {2'h0, iepb_pkg::IDX_PL, 2'h0};
  localparam logic [11:0] A_BIT = {2'h0, iepb_pkg::IDX_BITOP, 2'h0};
  localparam logic [11:0] A_ST = {2'h0, iepb_pkg::IDX_STAT, 2'h0};
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic go = 1'b0, dreq = 1'b0, ce = 1'b1, ack, done, pready, pslverr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwd = 32'h0, prdata;
  logic [6:0] req = 7'h0;
  logic [1:0] dly = 2'h0;
  logic [3:0] insvc;
  iepb_pkg::iepb_irq_t irq;
  iepb_exp_t expq[$];
  iepb_exp_t e;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  integer seed = 32'h74f2b224;

  iepb_ctrl DUT (.clock_in(clk), .rst_in(rst), .ce_in(ce), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .irq_req_in(req), .irq_ack_in(ack),
    .irq_done_in(done), .irq_out(irq), .in_service_out(insvc));
  iepb_cpu_model cpu (.clock_in(clk), .rst_in(rst), .irq_in(irq), .go_in(go),
    .done_req_in(dreq), .dly_in(dly), .ack_out(ack), .done_out(done));

  // ----
  // Helpers
  // ----
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // Idle cycle after each transfer keeps psel from two writes in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er);
    int n;
    expq.push_back('{!w && !er, d, er});
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= w ? d : 32'h0;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    @(posedge clk);
  endtask : apb
  task automatic chk_irq(input logic [5:0] x);
    repeat (3) @(posedge clk);
    if (x[5]) chk("irq", 32'(x), 32'(irq));
    else chk("irq_valid", 32'h0, 32'(irq.valid));
  endtask : chk_irq
  // Highest level above fl wins, lowest index among equals
  function automatic logic [5:0] best(input logic [6:0] ph, pl, rq, input int fl);
    logic [5:0] b;
    int lv;
    b = 6'h0;
    for (int s = 6; s >= 0; s--) begin
      lv = {ph[s], pl[s]};
      if (rq[s] && lv > fl && (!b[5] || lv >= b[1:0])) b = {1'b1, 3'(s), 2'(lv)};
    end
    return b;
  endfunction : best

  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (expq.size() == 0) begin
        chk("spare_ready", 32'h0, 32'h1);
      end else begin
        e = expq.pop_front();
        chk("pslverr", 32'(e.er), 32'(pslverr));
        if (e.rd) chk("prdata", e.d, prdata);
      end
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ----
  // Scenarios
  // ----
  initial begin
    logic [31:0] v;
    logic [6:0] rq;
    logic [5:0] w;
    int n;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, A_EN, 32'h0, 1'b0);
    apb(1'b0, A_PL, 32'h0, 1'b0);
    apb(1'b0, A_PH, 32'h0, 1'b0);
    apb(1'b0, 12'h004, 32'h0, 1'b1);
    v = $random(seed);
    apb(1'b1, A_EN, v, 1'b0);
    apb(1'b1, A_PL, v & 32'h7f, 1'b0);
    apb(1'b1, A_PH, ~v & 32'h7f, 1'b0);
    apb(1'b1, A_BIT, 32'h103, 1'b0);
    apb(1'b1, A_BIT, 32'h013, 1'b0);
    apb(1'b1, A_BIT, 32'h120, 1'b1);
    apb(1'b1, A_EN + 12'h1, 32'h0, 1'b1);
    apb(1'b1, A_ST, 32'h0, 1'b1);
    apb(1'b0, A_EN, {24'h0, v[7:0] | 8'h08}, 1'b0);
    apb(1'b0, A_PL, v & 32'h77, 1'b0);
    apb(1'b0, A_PH, ~v & 32'h7f, 1'b0);
    apb(1'b1, A_PH, 32'h0, 1'b0);
    apb(1'b1, A_PL, 32'h0, 1'b0);
    for (int s = 0; s < 7; s++) begin
      req <= 7'h1 << s;
      apb(1'b1, A_EN, 32'h80 | (32'h1 << s), 1'b0);
      chk_irq({1'b1, 3'(s), 2'h0});
      apb(1'b0, A_ST, 32'h80 | s, 1'b0);
      apb(1'b1, A_EN, 32'h7f, 1'b0);
      chk_irq(6'h00);
      apb(1'b1, A_EN, 32'hff ^ (32'h1 << s), 1'b0);
      chk_irq(6'h00);
    end
    for (int k = 0; k < 14; k++) begin
      v = $random(seed);
      rq = v[22:16] | (7'h1 << (k % 7));
      req <= rq;
      dly <= v[25:24];
      apb(1'b1, A_PH, {25'h0, v[6:0]}, 1'b0);
      apb(1'b1, A_PL, {25'h0, v[14:8]}, 1'b0);
      apb(1'b1, A_EN, 32'hff, 1'b0);
      w = best(v[6:0], v[14:8], rq, -1);
      chk_irq(w);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      while (insvc === 4'h0 && n < 20) begin
        @(posedge clk);
        n++;
      end
      chk("in_service", 32'h1 << w[1:0], 32'(insvc));
      apb(1'b0, A_ST, 32'h100 << w[1:0], 1'b0);
      chk_irq(best(v[6:0], v[14:8], rq, int'(w[1:0])));
      dreq <= 1'b1;
      @(posedge clk);
      dreq <= 1'b0;
      repeat (3) @(posedge clk);
      chk("in_service", 32'h0, 32'(insvc));
    end
    // Clock enable low must hold the standing offer despite dropped requests
    ce <= 1'b0;
    req <= 7'h0;
    chk_irq(w);
    ce <= 1'b1;
    chk_irq(6'h00);
    wrap_up();
  end
endmodule : test_int_enable_priority_bank0

`default_nettype wire
